// *** common/gar_pkg.sv ***
// Purpose: Shared constants and types for the rate sensor command readout
// Assumes: 200 MHz system clock
// Notes:   Serial frame is 8 instruction bits, then 16 answer bits
package gar_pkg;

    // ========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int CONV_TIME_NS  = 115000;
    // Longest time, so rounded down
    localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] BUSY_CYCLES = 8'hc8;

    // ========================================================
    // Frame layout
    localparam logic [4:0] CMD_BITS   = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h18;

    // ========================================================
    // Instruction codes and fields
    localparam logic [7:0] CTL_MASK     = 8'hf3;
    localparam logic [7:0] CTL_CODE     = 8'h90;
    localparam logic [7:0] READ_CODE    = 8'h80;
    localparam logic [7:0] STAT_CODE    = 8'h88;
    localparam int         CTL_INPUT_SELECT_FLAG_BIT = 3;
    localparam int         CTL_EN_BIT   = 2;

    // ========================================================
    // Answer fields
    localparam int ANS_REFUSE_BIT = 15;
    localparam int ANS_BAD_BIT    = 14;
    localparam int ANS_DONE_BIT   = 13;
    localparam int ANS_BUSY_BIT   = 10;
    localparam int ANS_INPUT_SELECT_FLAG_BIT   = 3;
    localparam int ANS_EN_BIT     = 2;
    localparam int ANS_RES_MSB    = 11;
    localparam int ANS_RES_LSB    = 1;
    localparam int RES_BITS       = 11;

    // ========================================================
    // Reset values
    localparam logic       INPUT_SELECT_FLAG_RST   = 1'b0;
    localparam logic       EN_RST     = 1'b0;
    localparam logic       DONE_RST   = 1'b1;
    localparam logic [10:0] RES_RST   = 11'h000;

    typedef enum logic [1:0] {OP_CTL, OP_READ, OP_STAT, OP_BAD} gar_op_t;

    function automatic gar_op_t decode_op(input logic [7:0] code);
        if ((code & CTL_MASK) == CTL_CODE)
            return OP_CTL;
        else if (code == READ_CODE)
            return OP_READ;
        else if (code == STAT_CODE)
            return OP_STAT;
        else
            return OP_BAD;
    endfunction

endpackage

// *** common/gar_adc_if.sv ***
// Purpose: Link between command logic and converter sequencer
// Assumes: Both ends on clk_in
// Notes:   start is a one-cycle pulse
`timescale 1ns/10ps
interface gar_adc_if;
    logic        start;
    logic        input_select_flag;
    logic        en;
    logic        done;
    logic [10:0] result;

    modport ctl (output start, input_select_flag, en, input done, result);
    modport cvt (input start, input_select_flag, en, output done, result);
endinterface

// *** design/gar_conv.sv ***
// Purpose: Converter sequencer: runs a timed conversion, holds result
// Assumes: Codes on rate/temp inputs are stable, same clock domain
// Notes:   Start is only honoured when idle and enabled
`timescale 1ns/10ps
module gar_conv #(
    parameter int CONV_CYC = gar_pkg::CONV_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Command side
    gar_adc_if.cvt           adc,
    // Analog front end codes
    input  wire logic [10:0] rate_code_in,
    input  wire logic [10:0] temp_code_in
);

    logic [14:0] cnt_ff;
    logic [14:0] nxt_cnt;
    logic        done_ff;
    logic        nxt_done;
    logic        ch_ff;
    logic        nxt_ch;
    logic [10:0] res_ff;
    logic [10:0] nxt_res;

    // ========================================================
    // Conversion sequencing
    always_comb
    begin
        nxt_cnt  = cnt_ff;
        nxt_done = done_ff;
        nxt_ch   = ch_ff;
        nxt_res  = res_ff;
        if (done_ff && adc.start && adc.en)
        begin
            nxt_done = 1'b0;
            nxt_cnt  = 15'(CONV_CYC - 1);
            nxt_ch   = adc.input_select_flag;
        end
        else if (!done_ff)
        begin
            if (cnt_ff == 15'h0000)
            begin
                nxt_done = 1'b1;
                // Result only moves at completion
                nxt_res  = ch_ff ? temp_code_in : rate_code_in;
            end
            else
            begin
                nxt_cnt = cnt_ff - 15'h0001;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            cnt_ff  <= 15'h0000;
            done_ff <= gar_pkg::DONE_RST;
            ch_ff   <= gar_pkg::INPUT_SELECT_FLAG_RST;
            res_ff  <= gar_pkg::RES_RST;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            done_ff <= nxt_done;
            ch_ff   <= nxt_ch;
            res_ff  <= nxt_res;
        end
    end

    assign adc.done   = done_ff;
    assign adc.result = res_ff;

    // ========================================================
    // Checks
    property p_res_hold;
        @(posedge clk_in) disable iff (sys_rst_in)
        !(!done_ff && cnt_ff == 15'h0000) |=> $stable(res_ff);
    endproperty
    a_res_hold: assert property (p_res_hold)
        else $error("Result changed without a completion");

    property p_run_low;
        @(posedge clk_in) disable iff (sys_rst_in)
        (done_ff && adc.start && adc.en) |=> !done_ff [*8];
    endproperty
    a_run_low: assert property (p_run_low)
        else $error("Done flag set too early after start");

endmodule

// *** design/gar_top.sv ***
// Purpose: Serial command handling for the embedded rate converter
// Assumes: Host clocks mode 0, sampling on rising edge; frame = ss low
// Notes:   All link pins pass two flops; edges found on clk_in
//
// Operation
// - Control byte 1001, select bit3, enable bit2
// - Control answer: bit15 zero, done, select, enable
// - Read instruction is 0x80 exactly
// - Read answer: done bit13, result bits 11..1
// - Result meaningful only while done is set
// - Bytes and words move most significant first
// - Done low while converting, set on completion
// - Refusal sets bit15 with bad, done, busy
// - Start refused while conversion still running
// - Select zero rate, one temperature; reset zero
// - Enable zero sleeps converter; reset zero
`timescale 1ns/10ps
module gar_top #(
    parameter int CONV_CYC = gar_pkg::CONV_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Serial link
    input  wire logic        sclk_in,
    input  wire logic        ss_n_in,
    input  wire logic        mosi_in,
    output logic             miso_out,
    output logic             miso_oe_out,
    // Converter front end codes
    input  wire logic [10:0] rate_code_in,
    input  wire logic [10:0] temp_code_in,
    // Status
    output logic             input_select_flag_sel_out,
    output logic             conv_enable_out,
    output logic             conv_done_out,
    output logic             init_busy_out
);

    gar_adc_if adc ();

    gar_conv #(
        .CONV_CYC (CONV_CYC)
    ) u_conv (
        .clk_in       (clk_in),
        .sys_rst_in   (sys_rst_in),
        .adc          (adc),
        .rate_code_in (rate_code_in),
        .temp_code_in (temp_code_in)
    );

    // ========================================================
    // Pin synchronisers
    logic [2:0] sclk_sync_ff;
    logic [2:0] nxt_sclk_sync;
    logic [1:0] ss_sync_ff;
    logic [1:0] nxt_ss_sync;
    logic [1:0] mosi_sync_ff;
    logic [1:0] nxt_mosi_sync;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       ss_act;
    logic       mosi_bit;

    always_comb
    begin
        nxt_sclk_sync = {sclk_sync_ff[1:0], sclk_in};
        nxt_ss_sync   = {ss_sync_ff[0], ss_n_in};
        nxt_mosi_sync = {mosi_sync_ff[0], mosi_in};
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            sclk_sync_ff <= 3'h0;
            ss_sync_ff   <= 2'h3;
            mosi_sync_ff <= 2'h0;
        end
        else
        begin
            sclk_sync_ff <= nxt_sclk_sync;
            ss_sync_ff   <= nxt_ss_sync;
            mosi_sync_ff <= nxt_mosi_sync;
        end
    end

    assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
    assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
    assign ss_act    = ~ss_sync_ff[1];
    assign mosi_bit  = mosi_sync_ff[1];

    // ========================================================
    // Power-up initialisation window
    logic [7:0] busy_cnt_ff;
    logic [7:0] nxt_busy_cnt;
    logic       busy_ff;
    logic       nxt_busy;

    always_comb
    begin
        nxt_busy_cnt = busy_cnt_ff;
        nxt_busy     = busy_ff;
        if (busy_ff)
        begin
            if (busy_cnt_ff == gar_pkg::BUSY_CYCLES - 8'h01)
                nxt_busy = 1'b0;
            else
                nxt_busy_cnt = busy_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            busy_cnt_ff <= 8'h00;
            busy_ff     <= 1'b1;
        end
        else
        begin
            busy_cnt_ff <= nxt_busy_cnt;
            busy_ff     <= nxt_busy;
        end
    end

    // ========================================================
    // Frame, decode and answer
    logic [4:0]       cnt_ff;
    logic [4:0]       nxt_cnt;
    logic [7:0]       in_ff;
    logic [7:0]       nxt_in;
    logic [15:0]      ans_ff;
    logic [15:0]      nxt_ans;
    logic             input_select_flag_ff;
    logic             nxt_input_select_flag;
    logic             en_ff;
    logic             nxt_en;
    logic             cmd_take;
    logic [7:0]       cmd_byte;
    gar_pkg::gar_op_t op;
    logic             refuse;
    logic             start;

    assign cmd_byte = {in_ff[6:0], mosi_bit};
    assign op       = gar_pkg::decode_op(cmd_byte);

    always_comb
    begin
        nxt_cnt  = cnt_ff;
        nxt_in   = in_ff;
        nxt_ans  = ans_ff;
        nxt_input_select_flag = input_select_flag_ff;
        nxt_en   = en_ff;
        cmd_take = 1'b0;
        refuse   = 1'b0;
        start    = 1'b0;
        if (!ss_act)
        begin
            // Frame abort drops a partial instruction
            nxt_cnt = 5'h00;
            nxt_ans = 16'h0000;
        end
        else
        begin
            if (sclk_rise && cnt_ff < gar_pkg::FRAME_BITS)
                nxt_cnt = cnt_ff + 5'h01;
            if (sclk_rise && cnt_ff < gar_pkg::CMD_BITS)
                nxt_in = cmd_byte;
            if (sclk_rise && cnt_ff == gar_pkg::CMD_BITS - 5'h01)
                cmd_take = 1'b1;
            // Bit 15 stands through the 9th rising edge
            if (sclk_fall && cnt_ff > gar_pkg::CMD_BITS)
                nxt_ans = {ans_ff[14:0], 1'b0};
        end
        if (cmd_take)
        begin
            refuse = busy_ff || op == gar_pkg::OP_BAD
                  || (op == gar_pkg::OP_CTL && !adc.done);
            nxt_ans = 16'h0000;
            nxt_ans[gar_pkg::ANS_DONE_BIT] = adc.done;
            if (refuse)
            begin
                nxt_ans[gar_pkg::ANS_REFUSE_BIT] = 1'b1;
                nxt_ans[gar_pkg::ANS_BAD_BIT]    = op == gar_pkg::OP_BAD;
                nxt_ans[gar_pkg::ANS_BUSY_BIT]   = busy_ff;
            end
            else if (op == gar_pkg::OP_READ)
            begin
                // Result bits are stale while done is low
                nxt_ans[gar_pkg::ANS_RES_MSB:gar_pkg::ANS_RES_LSB] =
                    adc.result;
            end
            else
            begin
                if (op == gar_pkg::OP_CTL)
                begin
                    nxt_input_select_flag = cmd_byte[gar_pkg::CTL_INPUT_SELECT_FLAG_BIT];
                    nxt_en   = cmd_byte[gar_pkg::CTL_EN_BIT];
                    start    = cmd_byte[gar_pkg::CTL_EN_BIT];
                end
                nxt_ans[gar_pkg::ANS_INPUT_SELECT_FLAG_BIT] = nxt_input_select_flag;
                nxt_ans[gar_pkg::ANS_EN_BIT]   = nxt_en;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            cnt_ff  <= 5'h00;
            in_ff   <= 8'h00;
            ans_ff  <= 16'h0000;
            input_select_flag_ff <= gar_pkg::INPUT_SELECT_FLAG_RST;
            en_ff   <= gar_pkg::EN_RST;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            in_ff   <= nxt_in;
            ans_ff  <= nxt_ans;
            input_select_flag_ff <= nxt_input_select_flag;
            en_ff   <= nxt_en;
        end
    end

    assign adc.start       = start;
    // New select must reach the sequencer in the start cycle
    assign adc.input_select_flag        = nxt_input_select_flag;
    assign adc.en          = nxt_en;
    assign miso_out        = ans_ff[15];
    assign miso_oe_out     = ss_act && cnt_ff >= gar_pkg::CMD_BITS;
    assign input_select_flag_sel_out    = input_select_flag_ff;
    assign conv_enable_out = en_ff;
    assign conv_done_out   = adc.done;
    assign init_busy_out   = busy_ff;

    // ========================================================
    // Checks
    property p_ctl_ans;
        @(posedge clk_in) disable iff (sys_rst_in)
        (cmd_take && !refuse && op == gar_pkg::OP_CTL)
        |=> !ans_ff[15] && ans_ff[3:2] == {input_select_flag_ff, en_ff};
    endproperty
    a_ctl_ans: assert property (p_ctl_ans)
        else $error("Control answer fields wrong");

    property p_read_ans;
        @(posedge clk_in) disable iff (sys_rst_in)
        (cmd_take && !refuse && op == gar_pkg::OP_READ)
        |=> !ans_ff[15] && !ans_ff[0] && ans_ff[11:1] == $past(adc.result);
    endproperty
    a_read_ans: assert property (p_read_ans)
        else $error("Read answer fields wrong");

    property p_read_code;
        @(posedge clk_in) disable iff (sys_rst_in)
        (cmd_take && !busy_ff && cmd_byte == 8'h80) |=> !ans_ff[15];
    endproperty
    a_read_code: assert property (p_read_code)
        else $error("Read instruction not accepted");

    property p_refuse;
        @(posedge clk_in) disable iff (sys_rst_in)
        (cmd_take && (busy_ff || op == gar_pkg::OP_BAD))
        |=> ans_ff[15] && ans_ff[10] == $past(busy_ff);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("Refusal answer missing");

    property p_no_restart;
        @(posedge clk_in) disable iff (sys_rst_in)
        (cmd_take && op == gar_pkg::OP_CTL && !adc.done)
        |-> !start ##1 ans_ff[15] && $stable(en_ff);
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("Running conversion was restarted");

    property p_msb_first;
        @(posedge clk_in) disable iff (sys_rst_in)
        (ss_act && sclk_fall && cnt_ff > gar_pkg::CMD_BITS)
        |=> miso_out == $past(ans_ff[14]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("Answer shift order wrong");

    property p_flags_rst;
        @(posedge clk_in) disable iff (sys_rst_in)
        $past(sys_rst_in) |-> !input_select_flag_sel_out && !conv_enable_out;
    endproperty
    a_flags_rst: assert property (p_flags_rst)
        else $error("Flags not cleared by reset");

    property p_sleep;
        @(posedge clk_in) disable iff (sys_rst_in)
        !en_ff && !start |=> $stable(adc.done) || adc.done;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("Conversion began while asleep");

endmodule

// *** bench/gar_host.sv ***
// Purpose: Host side of the serial link, drives whole or cut-short frames
// Assumes: Mode 0, sclk period 125 ns made from 25 clk_in cycles
// Notes:   Answer bits sampled just before each rise after bit 8
`timescale 1ns/10ps
module gar_host (
    // Clock
    input  wire logic clk_in,
    // Serial link
    input  wire logic miso_in,
    input  wire logic miso_oe_in,
    output logic      sclk_out,
    output logic      ss_n_out,
    output logic      mosi_out
);
    int oe_misses;

    initial
    begin
        sclk_out = 1'b0;
        ss_n_out = 1'b1;
        mosi_out = 1'b0;
        oe_misses = 0;
    end

    // ========================================================
    // Frame; fewer than 24 bits cuts it short, lead sets ss setup
    task automatic xfer(input logic [7:0] cmd, input int nbits,
                        input int lead, output logic [15:0] ans);
        ans = 16'h0000;
        @(posedge clk_in);
        ss_n_out <= 1'b0;
        repeat (lead) @(posedge clk_in);
        for (int i = 0; i < nbits; i++)
        begin
            // Toggle after the byte so stale data never looks valid
            mosi_out <= (i < 8) ? cmd[7 - i] : ~mosi_out;
            repeat (12) @(posedge clk_in);
            if (i >= 8)
            begin
                ans[23 - i] = miso_in;
                if (miso_oe_in !== 1'b1)
                    oe_misses++;
            end
            sclk_out <= 1'b1;
            repeat (13) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (12) @(posedge clk_in);
        ss_n_out <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask
endmodule

// *** bench/gar_top_tb.sv ***
// Purpose: Self-checking bench for the command readout
// Assumes: Shortened conversion of 2000 cycles
// Notes:   Codes held steady across each conversion
`timescale 1ns/10ps
module gar_top_tb;
    localparam int CONV = 2000;
    logic        clk_in;
    logic        sys_rst_in;
    logic        sclk;
    logic        ss_n;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    logic [10:0] rate_code;
    logic [10:0] temp_code;
    logic        input_select_flag_sel;
    logic        conv_en;
    logic        conv_done;
    logic        init_busy;
    logic [31:0] rnd;
    logic [15:0] ans;
    int          mismatches;
    int          num_checks;

    gar_top #(.CONV_CYC(CONV)) i_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk),
        .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso),
        .miso_oe_out(miso_oe), .rate_code_in(rate_code),
        .temp_code_in(temp_code), .input_select_flag_sel_out(input_select_flag_sel),
        .conv_enable_out(conv_en), .conv_done_out(conv_done),
        .init_busy_out(init_busy));

    gar_host i_host (
        .clk_in(clk_in), .miso_in(miso), .miso_oe_in(miso_oe),
        .sclk_out(sclk), .ss_n_out(ss_n), .mosi_out(mosi));

    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // ========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic known(input logic [7:0] c);
        return ((c & 8'hf3) == 8'h90) || (c == 8'h80) || (c == 8'h88);
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk_in);
        mismatches++;
        $display("unexpected timeout");
        final_report();
    end

    // ========================================================
    // Main sequence
    initial
    begin
        logic [7:0]  c;
        logic        ch;
        logic [10:0] res;
        logic [7:0]  odd [4];
        int          w;
        odd = '{8'h91, 8'h81, 8'h00, 8'h92};
        sys_rst_in = 1'b1;
        rate_code = 11'h000;
        temp_code = 11'h000;
        rnd = 32'hfa02;
        mismatches = 0;
        num_checks = 0;
        res = 11'h000;
        repeat (5) @(posedge clk_in);
        check("reset flags", {12'h0, input_select_flag_sel, conv_en, conv_done,
              miso_oe}, 16'h0002);
        sys_rst_in <= 1'b0;
        // Frame started at release is taken while still busy
        i_host.xfer(8'h80, 24, 0, ans);
        check("busy refusal", ans & 16'he400, 16'ha400);
        w = 0;
        while (init_busy !== 1'b0 && w < 400)
        begin
            @(posedge clk_in);
            w++;
        end
        check("busy", {15'h0, init_busy}, 16'h0000);
        // Near-miss codes first, then random unknown ones
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            c = (i < 4) ? odd[i] : (known(rnd[7:0]) ? 8'h55 : rnd[7:0]);
            i_host.xfer(c, 24, 2, ans);
            check("refusal", ans & 16'he400, 16'he000);
        end
        i_host.xfer(8'h94, 5, 2, ans);
        check("dropped", {15'h0, conv_en}, 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            // Select goes 0, 1, then back to 0 before random ones
            ch = (k < 3) ? (k == 1) : rnd[5];
            @(posedge clk_in);
            rate_code <= rnd[10:0];
            temp_code <= rnd[26:16];
            res = ch ? rnd[26:16] : rnd[10:0];
            c = 8'h94 | {4'h0, ch, 3'h0};
            i_host.xfer(c, 24, k[0] ? 40 : 2, ans);
            check("ctl answer", ans & 16'ha00c,
                  {3'b001, 9'h0, ch, 3'b100});
            check("flags", {14'h0, input_select_flag_sel, conv_en}, {14'h0, ch, 1'b1});
            check("done low", {15'h0, conv_done}, 16'h0000);
            i_host.xfer(8'h80, 24, 2, ans);
            check("early read", ans & 16'ha001, 16'h0000);
            i_host.xfer(c ^ 8'h08, 24, 2, ans);
            check("restart", ans & 16'he400, 16'h8000);
            check("kept", {14'h0, input_select_flag_sel, conv_en}, {14'h0, ch, 1'b1});
            if (k == 1)
                repeat (CONV + 40) @(posedge clk_in);
            else
            begin
                w = 0;
                while (conv_done !== 1'b1 && w < CONV + 100)
                begin
                    @(posedge clk_in);
                    w++;
                end
            end
            // New codes must not leak into the held result
            @(posedge clk_in);
            rate_code <= ~rate_code;
            temp_code <= ~temp_code;
            i_host.xfer(8'h80, 24, 2, ans);
            check("result", ans, {4'b0010, res, 1'b0});
            i_host.xfer(8'h88, 24, 2, ans);
            check("status", ans & 16'ha00c, {3'b001, 9'h0, ch, 3'b100});
            i_host.xfer(8'h80, 24, 40, ans);
            check("held", ans, {4'b0010, res, 1'b0});
        end
        i_host.xfer(8'h90, 24, 2, ans);
        check("sleep answer", ans & 16'ha00c, 16'h2000);
        repeat (10) @(posedge clk_in);
        check("asleep", {14'h0, conv_en, conv_done}, 16'h0001);
        i_host.xfer(8'h80, 14, 2, ans);
        check("short read", ans, {4'b0010, res[10:9], 10'h0});
        i_host.xfer(8'h80, 24, 2, ans);
        check("after short", ans, {4'b0010, res, 1'b0});
        check("drive", 16'(i_host.oe_misses), 16'h0000);
        final_report();
    end
endmodule
